// >>> hdl/clock_gating_pkg.sv
// Purpose: shared constants and types for the reference clock gating block
// Assumes: aclk at 50 MHz is the output clock source
// Notes: register offsets are byte addresses on the AXI4-Lite slave
package clock_gating_pkg;

	localparam int NUM_OUTPUTS = 9;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// clock figures
	localparam real CLK_PERIOD_NS = 20.0;
	localparam real STABLE_TIME_MS = 1.8;
	// longest time, so rounded down
	localparam int STABLE_CYCLES = $rtoi(STABLE_TIME_MS * 1.0E6 / CLK_PERIOD_NS);
	localparam int STABLE_CNT_W = 17;
	// aclk cycles per output clock cycle
	localparam int ACLK_PER_OUT = 2;
	localparam int ENABLE_LAT_MAX_OUT = 6;

	// register map
	localparam logic [ADDR_W-1:0] REG_OUTEN_ADDR = 8'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS_ADDR = 8'h04;
	localparam logic [NUM_OUTPUTS-1:0] OUTEN_RESET = 9'h1FF;

	// status field positions
	localparam int STAT_RUNNING_LSB = 0;
	localparam int STAT_POWERED_UP_BIT = 9;
	localparam int STAT_POWERDOWN_BIT = 10;
	localparam int STAT_STABLE_BIT = 11;
	localparam int STAT_SPREAD_BIT = 12;
	localparam int STAT_WAIT_PG_BIT = 13;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		PWR_WAIT_GOOD = 3'h1,
		PWR_RUN = 3'h2,
		PWR_DOWN = 3'h4
	} power_state_t;

endpackage : clock_gating_pkg

// >>> hdl/signal_sync.sv
// Purpose: two flip-flop synchroniser for a vector of pin levels
// Assumes: each bit is an independent level
// Notes: stage1 feeds only stage2
`timescale 1ns/100ps
`default_nettype none
module signal_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} sync_state_t;

	sync_state_t st;
	sync_state_t next_st;

	always_comb
	begin
		next_st = st;
		next_st.stage1 = async_in;
		next_st.stage2 = st.stage1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st <= '0;
		else
			st <= next_st;
	end

	assign sync_out = st.stage2;

endmodule : signal_sync
`default_nettype wire

// >>> hdl/output_gate.sv
// Purpose: glitch-free gate for one reference clock output
// Assumes: phase toggles every aclk; high phase is one aclk
// Notes: the gate only moves while the output clock is low
`timescale 1ns/100ps
`default_nettype none
module output_gate (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// control
	input wire logic phase,
	input wire logic want,
	// output
	output logic clk_out,
	output logic running
);

	typedef struct packed {
		logic open;
		logic out;
	} gate_state_t;

	gate_state_t st;
	gate_state_t next_st;

	always_comb
	begin
		next_st = st;
		// (R11) (R12) whole pulses, quick open
		// (R17) low phase only
		if (!phase)
			next_st.open = want;
		// (R13) stopped output sits low
		next_st.out = !phase && next_st.open;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st <= '0;
		else
			st <= next_st;
	end

	assign clk_out = st.out;
	assign running = st.open;

	chk_gate_low_phase: assert property (@(posedge aclk) disable iff (!aresetn) // (R17)
		(st.open != $past(st.open)) |-> !$past(phase))
		else $error("gate moved during high phase");

	chk_open_latency: assert property (@(posedge aclk) disable iff (!aresetn) // (R12)
		(want && !st.open) |-> ##[1:2] (st.open || !want))
		else $error("gate open too late");

	chk_stop_final_low: assert property (@(posedge aclk) disable iff (!aresetn) // (R13)
		!st.open |-> !st.out)
		else $error("closed gate drives high");

	chk_full_pulse: assert property (@(posedge aclk) disable iff (!aresetn) // (R11)
		$rose(st.out) |=> (!st.out ##1 (st.out || !st.open)))
		else $error("runt or stretched pulse");

endmodule : output_gate
`default_nettype wire

// >>> hdl/clock_output_gating_control.sv
// Purpose: run, stop and resume the reference clock outputs
// Assumes: control pins are asynchronous board levels
// Notes: outputs are clocks modelled as registered levels on aclk
// How it works
// (R1) power-good low keeps outputs off, oscillator on
// (R2) after good sampled, pin becomes power-down
// (R3) power-down asynchronous, stops outputs glitch-free
// (R4) power-down drives every output low
// (R5) power-down also stops oscillator and serial logic
// (R6) pin rise enables outputs in 2-6 cycles
// (R7) output runs only with pin and bit
// (R8) either enable low disables the output
// (R9) board must always drive enable pins
// (R10) per-output stop, others keep running
// (R11) resume gives no short or long pulses
// (R12) enable pin rise activates in 2-6 cycles
// (R13) stopped output ends driven low
// (R14) spread select high gives -0.5% downspread
// (R15) stable outputs within 1.8 ms of power-up
// (R16) one register enable bit per output
// (R17) gate changes only in low phase
`timescale 1ns/100ps
`default_nettype none
module clock_output_gating_control #(
	parameter int STABLE_CYCLES = clock_gating_pkg::STABLE_CYCLES
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [clock_gating_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	// AXI4-Lite write data
	input wire logic [clock_gating_pkg::DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read address
	input wire logic [clock_gating_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	// AXI4-Lite read data
	output logic [clock_gating_pkg::DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// board control pins
	input wire logic power_good_powerdown_pin,
	input wire logic spread_select,
	input wire logic [clock_gating_pkg::NUM_OUTPUTS-1:0] output_enable_pin,
	// clock outputs and analog controls
	output logic [clock_gating_pkg::NUM_OUTPUTS-1:0] ref_clock_output,
	output logic spread_enable,
	output logic oscillator_enable,
	output logic serial_enable
);

	localparam int N = clock_gating_pkg::NUM_OUTPUTS;
	localparam int LAT_MAX_ACLK = clock_gating_pkg::ENABLE_LAT_MAX_OUT *
		clock_gating_pkg::ACLK_PER_OUT;
	localparam logic [clock_gating_pkg::STABLE_CNT_W-1:0] STABLE_LAST =
		clock_gating_pkg::STABLE_CNT_W'(STABLE_CYCLES - 1);

	typedef struct packed {
		clock_gating_pkg::power_state_t pstate;
		logic [clock_gating_pkg::STABLE_CNT_W-1:0] stable_cnt;
		logic stable;
		logic phase;
		logic spread_on;
		logic [N-1:0] outen;
		logic aw_held;
		logic [clock_gating_pkg::ADDR_W-1:0] aw_addr;
		logic w_held;
		logic [clock_gating_pkg::DATA_W-1:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [clock_gating_pkg::DATA_W-1:0] rdata;
		logic [1:0] rresp;
	} ctrl_state_t;

	ctrl_state_t st;
	ctrl_state_t next_st;

	logic pg_sync;
	logic spread_sync;
	logic [N-1:0] oe_sync;
	logic [N-1:0] want;
	logic [N-1:0] running;
	logic [N-1:0] clk_out;
	logic [clock_gating_pkg::DATA_W-1:0] status_word;

	// (R3) pins are synchronised before any decision
	signal_sync #(
		.WIDTH(N + 2)
	) u_pin_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in({power_good_powerdown_pin, spread_select, output_enable_pin}),
		.sync_out({pg_sync, spread_sync, oe_sync})
	);

	// (R8) either enable low drops want
	// (R7) both enables, running power state and stable clocks
	assign want = ((st.pstate == clock_gating_pkg::PWR_RUN) && st.stable) ?
		(oe_sync & st.outen) : '0;

	genvar gi;
	generate
		for (gi = 0; gi < N; gi++)
		begin : g_out
			// (R10) each output has its own gate
			output_gate u_gate (
				.aclk(aclk),
				.aresetn(aresetn),
				.phase(st.phase),
				.want(want[gi]),
				.clk_out(clk_out[gi]),
				.running(running[gi])
			);
		end
	endgenerate

	always_comb
	begin
		status_word = '0;
		status_word[clock_gating_pkg::STAT_RUNNING_LSB +: N] = running;
		status_word[clock_gating_pkg::STAT_POWERED_UP_BIT] =
			(st.pstate == clock_gating_pkg::PWR_RUN);
		status_word[clock_gating_pkg::STAT_POWERDOWN_BIT] =
			(st.pstate == clock_gating_pkg::PWR_DOWN);
		status_word[clock_gating_pkg::STAT_STABLE_BIT] = st.stable;
		status_word[clock_gating_pkg::STAT_SPREAD_BIT] = st.spread_on;
		status_word[clock_gating_pkg::STAT_WAIT_PG_BIT] =
			(st.pstate == clock_gating_pkg::PWR_WAIT_GOOD);
	end

	always_comb
	begin
		next_st = st;
		// output clock runs at half of aclk
		next_st.phase = !st.phase;

		// (R15) stabilisation count from reset
		if (!st.stable)
		begin
			if (st.stable_cnt == STABLE_LAST)
				next_st.stable = 1'b1;
			else
				next_st.stable_cnt = st.stable_cnt + 1'b1;
		end

		// (R14) spread follows the sampled select level
		next_st.spread_on = spread_sync;

		case (st.pstate)
			clock_gating_pkg::PWR_WAIT_GOOD:
			begin
				// (R2) first high sample changes pin meaning
				if (pg_sync)
					next_st.pstate = clock_gating_pkg::PWR_RUN;
			end
			clock_gating_pkg::PWR_RUN:
			begin
				// (R2) low now means standby
				if (!pg_sync)
					next_st.pstate = clock_gating_pkg::PWR_DOWN;
			end
			clock_gating_pkg::PWR_DOWN:
			begin
				// (R6) rising edge resumes the outputs enabled by both pin and bit
				if (pg_sync)
					next_st.pstate = clock_gating_pkg::PWR_RUN;
			end
			default:
			begin
				next_st.pstate = clock_gating_pkg::PWR_WAIT_GOOD;
			end
		endcase

		// write address and data are taken in either order
		if (awvalid && awready)
		begin
			next_st.aw_held = 1'b1;
			next_st.aw_addr = awaddr;
		end
		if (wvalid && wready)
		begin
			next_st.w_held = 1'b1;
			next_st.w_data = wdata;
			next_st.w_strb = wstrb;
		end
		if (st.bvalid && bready)
			next_st.bvalid = 1'b0;
		if (st.aw_held && st.w_held && !st.bvalid)
		begin
			next_st.aw_held = 1'b0;
			next_st.w_held = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = clock_gating_pkg::RESP_OKAY;
			if (st.aw_addr == clock_gating_pkg::REG_OUTEN_ADDR)
			begin
				// (R5) serial logic is off in standby; write dropped
				if (st.pstate != clock_gating_pkg::PWR_DOWN)
				begin
					// (R16) one enable bit per output
					if (st.w_strb[0])
						next_st.outen[7:0] = st.w_data[7:0];
					if (st.w_strb[1])
						next_st.outen[N-1:8] = st.w_data[N-1:8];
				end
			end
			else if (st.aw_addr == clock_gating_pkg::REG_STATUS_ADDR)
			begin
				// status is read-only; write has no effect
				next_st.bresp = clock_gating_pkg::RESP_OKAY;
			end
			else
			begin
				next_st.bresp = clock_gating_pkg::RESP_SLVERR;
			end
		end

		// read channel, one outstanding
		if (st.rvalid && rready)
			next_st.rvalid = 1'b0;
		if (arvalid && arready)
		begin
			next_st.rvalid = 1'b1;
			next_st.rresp = clock_gating_pkg::RESP_OKAY;
			if (araddr == clock_gating_pkg::REG_OUTEN_ADDR)
				next_st.rdata = {{(clock_gating_pkg::DATA_W - N){1'b0}}, st.outen};
			else if (araddr == clock_gating_pkg::REG_STATUS_ADDR)
				next_st.rdata = status_word;
			else
			begin
				next_st.rdata = '0;
				next_st.rresp = clock_gating_pkg::RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st <= '0;
			st.pstate <= clock_gating_pkg::PWR_WAIT_GOOD;
			st.outen <= clock_gating_pkg::OUTEN_RESET;
		end
		else
			st <= next_st;
	end

	// AXI handshakes
	assign awready = !st.aw_held && !st.bvalid;
	assign wready = !st.w_held && !st.bvalid;
	assign bvalid = st.bvalid;
	assign bresp = st.bresp;
	assign arready = !st.rvalid;
	assign rvalid = st.rvalid;
	assign rdata = st.rdata;
	assign rresp = st.rresp;

	// (R4) gates are closed outside run, so outputs sit low
	assign ref_clock_output = clk_out;
	// (R14) spread control to the synthesiser
	assign spread_enable = st.spread_on;
	// (R1) (R5) oscillator and serial logic stop only in standby
	assign oscillator_enable = (st.pstate != clock_gating_pkg::PWR_DOWN);
	assign serial_enable = (st.pstate != clock_gating_pkg::PWR_DOWN);

	chk_pdown_outputs_low: assert property (@(posedge aclk) // (R4)
		disable iff (!aresetn)
		(st.pstate == clock_gating_pkg::PWR_DOWN) |=> (ref_clock_output == 9'h000))
		else $error("output high in power-down");

	chk_pdown_osc_off: assert property (@(posedge aclk) disable iff (!aresetn) // (R5)
		(st.pstate == clock_gating_pkg::PWR_DOWN) |->
		(!oscillator_enable && !serial_enable))
		else $error("oscillator or serial on in power-down");

	chk_wait_good_off: assert property (@(posedge aclk) disable iff (!aresetn) // (R1)
		(st.pstate == clock_gating_pkg::PWR_WAIT_GOOD) |->
		(oscillator_enable && running == 9'h000))
		else $error("outputs on before power good");

	chk_pin_to_down: assert property (@(posedge aclk) disable iff (!aresetn) // (R2)
		(st.pstate == clock_gating_pkg::PWR_RUN && !pg_sync) |=>
		(st.pstate == clock_gating_pkg::PWR_DOWN))
		else $error("power-down not entered");

	chk_resume_latency: assert property (@(posedge aclk) disable iff (!aresetn) // (R6)
		(st.pstate == clock_gating_pkg::PWR_DOWN && pg_sync && st.stable &&
		(oe_sync & st.outen) == 9'h1FF) ##1 ((oe_sync & st.outen) == 9'h1FF)[*4]
		|-> ##[0:LAT_MAX_ACLK] (running == 9'h1FF))
		else $error("outputs slow to resume");

	chk_both_enables: assert property (@(posedge aclk) disable iff (!aresetn) // (R7)
		(ref_clock_output & ~($past(st.outen) & $past(oe_sync))) == 9'h000)
		else $error("output runs without both enables");

	chk_bit_clear_stops: assert property (@(posedge aclk) // (R8)
		disable iff (!aresetn)
		((st.outen & oe_sync) != 9'h1FF) |-> ##[1:2]
		((running & ~($past(st.outen) & $past(oe_sync))) == 9'h000))
		else $error("output not stopped");

	chk_spread_follow: assert property (@(posedge aclk) disable iff (!aresetn) // (R14)
		$stable(spread_sync) |=> (spread_enable == $past(spread_sync)))
		else $error("spread does not follow select");

	chk_unstable_off: assert property (@(posedge aclk) disable iff (!aresetn) // (R15)
		!st.stable |-> (running == 9'h000))
		else $error("output before clocks stable");

	chk_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		(st.aw_held && st.w_held && !st.bvalid) |=> bvalid)
		else $error("write response missing");

	chk_wait_hold: assert property (@(posedge aclk) // (R1)
		disable iff (!aresetn)
		(st.pstate == clock_gating_pkg::PWR_WAIT_GOOD && !pg_sync) |=>
		(st.pstate == clock_gating_pkg::PWR_WAIT_GOOD))
		else $error("power-good wait left early");

	chk_resume_run: assert property (@(posedge aclk) // (R6)
		disable iff (!aresetn)
		(st.pstate == clock_gating_pkg::PWR_DOWN && pg_sync) |=>
		(st.pstate == clock_gating_pkg::PWR_RUN))
		else $error("no run after power-down release");

	chk_down_write_drop: assert property (@(posedge aclk) // (R5)
		disable iff (!aresetn)
		(st.pstate == clock_gating_pkg::PWR_DOWN) |=> $stable(st.outen))
		else $error("enable bits written in power-down");

	// full-strobe write outside standby lands whole
	chk_outen_write: assert property (@(posedge aclk) // (R16)
		disable iff (!aresetn)
		(st.aw_held && st.w_held && !st.bvalid && st.w_strb[1:0] == 2'h3 &&
		st.aw_addr == clock_gating_pkg::REG_OUTEN_ADDR &&
		st.pstate != clock_gating_pkg::PWR_DOWN) |=>
		(st.outen == $past(st.w_data[N-1:0])))
		else $error("enable bits not written");

endmodule : clock_output_gating_control
`default_nettype wire

// >>> verification/board_model.sv
// Purpose: board side of the block: control pins and clock receivers
// Assumes: the bench sets wanted levels, applied at the aclk rise
// Notes: a receiver only sees whole aclk phases, not analog runts
`timescale 1ns/100ps
`default_nettype none
module board_model (
	// clock
	input wire logic aclk,
	// wanted levels
	input wire logic pg_lvl,
	input wire logic ss_lvl,
	input wire logic [8:0] oe_lvl,
	// pins to the block
	output logic pg_pin,
	output logic ss_pin,
	output logic [8:0] oe_pin,
	// receivers
	input wire logic [8:0] clk_in,
	output logic stretch_err
);
	logic [8:0] prev;
	initial
	begin
		pg_pin = 1'b0;
		ss_pin = 1'b0;
		oe_pin = 9'h1FF;
		prev = 9'h000;
		stretch_err = 1'b0;
	end
	always @(posedge aclk)
	begin
		pg_pin <= pg_lvl;
		ss_pin <= ss_lvl;
		oe_pin <= oe_lvl;
		prev <= clk_in;
		// high phase never over one aclk
		if ((prev & clk_in) != 9'h000)
			stretch_err <= 1'b1;
	end
endmodule : board_model
`default_nettype wire

// >>> verification/tb.sv
// Purpose: self-checking bench for the clock output gating block
// Assumes: stabilisation shortened to STAB aclk cycles
// Notes: pin levels reach the block through board_model
`timescale 1ns/100ps
`default_nettype none
module tb;
	localparam int STAB = 8;
	localparam int LIMIT = 3000;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata, d;
	logic pg_lvl = 1'b0;
	logic ss_lvl = 1'b0;
	logic [8:0] oe_lvl = 9'h1FF;
	logic pg_pin, ss_pin, stretch_err;
	logic spread_enable, oscillator_enable, serial_enable;
	logic [8:0] oe_pin, ref_clock_output, s;
	int n_checks = 0;
	int n_fail = 0;
	int cyc = 0;
	int c;

	clock_output_gating_control #(.STABLE_CYCLES(STAB)) dut (
		.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.power_good_powerdown_pin(pg_pin), .spread_select(ss_pin),
		.output_enable_pin(oe_pin), .ref_clock_output(ref_clock_output),
		.spread_enable(spread_enable),
		.oscillator_enable(oscillator_enable),
		.serial_enable(serial_enable)
	);

	board_model bm (
		.aclk(aclk), .pg_lvl(pg_lvl), .ss_lvl(ss_lvl), .oe_lvl(oe_lvl),
		.pg_pin(pg_pin), .ss_pin(ss_pin), .oe_pin(oe_pin),
		.clk_in(ref_clock_output), .stretch_err(stretch_err)
	);

	initial
	begin
		forever #10 aclk = ~aclk;
	end

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up

	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == LIMIT)
		begin
			n_fail++;
			wrap_up;
		end
	end

	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
		end
	endtask : chk

	// ready is combinational, so it is sampled mid-cycle
	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		output logic [1:0] rs);
		logic aw_go, w_go, b_go;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(negedge aclk);
			aw_go = awvalid && awready;
			w_go = wvalid && wready;
			b_go = bvalid;
			rs = bresp;
			@(posedge aclk);
			if (aw_go)
				awvalid <= 1'b0;
			if (w_go)
				wvalid <= 1'b0;
		end while (!b_go);
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] v,
		output logic [1:0] rs);
		logic ar_go, r_go;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(negedge aclk);
			ar_go = arvalid && arready;
			r_go = rvalid;
			v = rdata;
			rs = rresp;
			@(posedge aclk);
			if (ar_go)
				arvalid <= 1'b0;
		end while (!r_go);
		rready <= 1'b0;
	endtask : rd

	// cycles until every output in m has shown a high phase
	task automatic lat(input logic [8:0] m, output int n);
		logic [8:0] seen;
		seen = 9'h000;
		n = 0;
		while ((seen & m) != m && n < 100)
		begin
			@(negedge aclk);
			seen = seen | ref_clock_output;
			n++;
		end
	endtask : lat

	task automatic idle(input int n, output logic [8:0] seen);
		seen = 9'h000;
		repeat (n)
		begin
			@(negedge aclk);
			seen = seen | ref_clock_output;
		end
	endtask : idle

	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		idle(20, s);
		chk("off before good", s, 0);
		chk("osc on", oscillator_enable, 1);
		chk("serial on", serial_enable, 1);
		rd(8'h00, d, r);
		chk("outen reset", d, 32'h1FF);
		wr(8'h04, 32'h0, r);
		chk("status wr", r, clock_gating_pkg::RESP_OKAY);
		rd(8'h04, d, r);
		chk("wait flag", d[13], 1);
		rd(8'h08, d, r);
		chk("unmapped rd", r, clock_gating_pkg::RESP_SLVERR);
		wr(8'h08, 32'h0, r);
		chk("unmapped wr", r, clock_gating_pkg::RESP_SLVERR);
		$display("test power good done");
		pg_lvl <= 1'b1;
		lat(9'h1FF, c);
		chk("good latency", c <= 12, 1);
		rd(8'h04, d, r);
		chk("run state", d[9], 1);
		$display("test start done");
		oe_lvl <= 9'h1F7;
		repeat (8) @(negedge aclk);
		idle(16, s);
		chk("pin stop", s, 9'h1F7);
		oe_lvl <= 9'h1FF;
		lat(9'h008, c);
		chk("pin latency", c <= 12, 1);
		$display("test enable pin done");
		wr(8'h00, 32'h1FD, r);
		chk("outen wr", r, clock_gating_pkg::RESP_OKAY);
		rd(8'h00, d, r);
		chk("outen rd", d, 32'h1FD);
		oe_lvl <= 9'h1FE;
		repeat (8) @(negedge aclk);
		idle(16, s);
		chk("both needed", s, 9'h1FC);
		oe_lvl <= 9'h1FF;
		@(posedge aclk);
		wstrb <= 4'h2;
		wr(8'h00, 32'h0, r);
		wstrb <= 4'hF;
		rd(8'h00, d, r);
		chk("strobe byte1", d, 32'h0FD);
		wr(8'h00, 32'h1FF, r);
		lat(9'h1FF, c);
		chk("bit resume", c <= 12, 1);
		$display("test enable bit done");
		ss_lvl <= 1'b1;
		repeat (6) @(negedge aclk);
		chk("spread on", spread_enable, 1);
		rd(8'h04, d, r);
		chk("spread flag", d[12], 1);
		chk("stable flag", d[11], 1);
		ss_lvl <= 1'b0;
		repeat (6) @(negedge aclk);
		chk("spread off", spread_enable, 0);
		$display("test spread done");
		pg_lvl <= 1'b0;
		repeat (8) @(negedge aclk);
		idle(16, s);
		chk("down low", s, 0);
		chk("osc off", oscillator_enable, 0);
		chk("serial off", serial_enable, 0);
		rd(8'h04, d, r);
		chk("down flag", d[10], 1);
		wr(8'h00, 32'h000, r);
		rd(8'h00, d, r);
		chk("down wr dropped", d, 32'h1FF);
		pg_lvl <= 1'b1;
		lat(9'h1FF, c);
		chk("resume latency", c <= 12, 1);
		$display("test power down done");
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		lat(9'h1FF, c);
		chk("stable time", c <= STAB + 12, 1);
		chk("no stretch", stretch_err, 0);
		$display("test restart done");
		wrap_up;
	end
endmodule : tb
`default_nettype wire
